// file: ctm_pkg.sv
// Package: constants and types for the cyclic torque mode control block
// Overview of operation
// - Mode value 10 selects cyclic torque
// - Output follows queued target torque, one per sync
// - Control bit 2 low: fast stop
// - One fault reset per bit 7 rise
// - Bit 7 high masks other commands
// - Unsupported control and status bits inert
// - Status 0,1,4 ready; 2 operation enabled
// - Status 3 fault, 7 alarm
// - Status 5 low during quick stop
// - Status 6 when cannot be enabled
// - Status 9 once control word effective
// - Status 10 and 12 set in cyclic torque mode
// - Status 11 follows software limit
// - Value 128 rising edge clears a clearable alarm
// - Latch position on input or index change
// - Two probes, rising and falling latches
// - Single mode first event, continuous every
package ctm_pkg;
  localparam logic [15:0] CTM_OFS_CONTROL_WORD   = 16'h6040;
  localparam logic [15:0] CTM_OFS_STATUS_WORD    = 16'h6041;
  localparam logic [15:0] CTM_OFS_MODE_SELECT    = 16'h6060;
  localparam logic [15:0] CTM_OFS_MODE_DISPLAY   = 16'h6061;
  localparam logic [15:0] CTM_OFS_TARGET_TORQUE  = 16'h6071;
  localparam logic [15:0] CTM_OFS_MAX_TORQUE     = 16'h6072;
  localparam logic [15:0] CTM_OFS_TORQUE_DEMAND  = 16'h6074;
  localparam logic [15:0] CTM_OFS_MEAS_TORQUE    = 16'h6077;
  localparam logic [15:0] CTM_OFS_CMD_POLARITY   = 16'h607E;
  localparam logic [15:0] CTM_OFS_MAX_SPEED      = 16'h607F;
  localparam logic [15:0] CTM_OFS_TORQUE_OFFSET  = 16'h60B2;
  localparam logic [15:0] CTM_OFS_FWD_LIMIT      = 16'h60E0;
  localparam logic [15:0] CTM_OFS_REV_LIMIT      = 16'h60E1;

  localparam logic [15:0] CTM_RST_CONTROL_WORD   = 16'h0000;
  localparam logic [7:0]  CTM_RST_MODE_SELECT    = 8'h00;
  localparam logic [15:0] CTM_RST_TARGET_TORQUE  = 16'h0000;
  localparam logic [15:0] CTM_RST_MAX_TORQUE     = 16'h0BB8;
  localparam logic [7:0]  CTM_RST_CMD_POLARITY   = 8'h00;
  localparam logic [31:0] CTM_RST_MAX_SPEED      = 32'h0640_0000;
  localparam logic [15:0] CTM_RST_TORQUE_OFFSET  = 16'h0000;
  localparam logic [15:0] CTM_RST_FWD_LIMIT      = 16'h0BB8;
  localparam logic [15:0] CTM_RST_REV_LIMIT      = 16'h0BB8;

  localparam logic [7:0]  CTM_MODE_CYCLIC_TORQUE = 8'h0A;

  localparam int CTM_CW_SWITCH_ON   = 0;
  localparam int CTM_CW_EN_VOLTAGE  = 1;
  localparam int CTM_CW_QUICK_STOP  = 2;
  localparam int CTM_CW_OP_ENABLE   = 3;
  localparam int CTM_CW_FAULT_RESET = 7;

  localparam int CTM_SW_READY       = 0;
  localparam int CTM_SW_SWITCHED_ON = 1;
  localparam int CTM_SW_OP_ENABLED  = 2;
  localparam int CTM_SW_FAULT       = 3;
  localparam int CTM_SW_VOLTAGE     = 4;
  localparam int CTM_SW_QUICK_STOP  = 5;
  localparam int CTM_SW_ON_DISABLED = 6;
  localparam int CTM_SW_ALARM       = 7;
  localparam int CTM_SW_REMOTE      = 9;
  localparam int CTM_SW_TARGET      = 10;
  localparam int CTM_SW_SW_LIMIT    = 11;
  localparam int CTM_SW_FOLLOWING   = 12;

  localparam int CTM_FIFO_WIDTH = 16;
  localparam int CTM_FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    CTM_ST_ON_DISABLED = 3'b000,
    CTM_ST_READY       = 3'b001,
    CTM_ST_SWITCHED_ON = 3'b010,
    CTM_ST_OP_ENABLED  = 3'b011,
    CTM_ST_QUICK_STOP  = 3'b100,
    CTM_ST_FAULT       = 3'b101
  } ctm_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ctm_obj_req_t;

  typedef struct packed {
    logic        en;
    logic        continuous;
    logic        sel_index;
    logic        pos_en;
    logic        neg_en;
  } ctm_probe_cfg_t;
endpackage

// file: ctm_fifo.sv
// Module: small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ctm_fifo
  import ctm_pkg::*;
#(
  parameter int WIDTH = CTM_FIFO_WIDTH,
  parameter int DEPTH = CTM_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: ctm_top.sv
// Module: cyclic torque mode control word, status word, torque path and probes
`timescale 1ns/100ps
`default_nettype none
module ctm_top
  import ctm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire ctm_obj_req_t obj_req,
  output logic              obj_ready,
  output logic       [31:0] obj_rdata,
  output logic              obj_rvalid,
  input  wire logic         sync_pulse,
  input  wire logic         fault_in,
  input  wire logic         alarm_in,
  input  wire logic         alarm_clearable,
  input  wire logic         sw_limit_in,
  input  wire logic  [15:0] measured_torque_in,
  input  wire logic  [31:0] position_in,
  input  wire logic  [1:0]  probe_di_in,
  input  wire logic         encoder_index_in,
  input  wire ctm_probe_cfg_t probe1_cfg,
  input  wire ctm_probe_cfg_t probe2_cfg,
  output logic       [15:0] torque_cmd,
  output logic              quick_stop_active,
  output logic              fault_reset_pulse,
  output logic              alarm_clear_pulse,
  output logic       [31:0] probe_pos [4],
  output logic       [3:0]  probe_latched
);
  logic [15:0] control_word_r;
  logic [7:0]  mode_select_r;
  logic [15:0] max_torque_r;
  logic [7:0]  cmd_polarity_r;
  logic [31:0] max_speed_r;
  logic [15:0] torque_offset_r;
  logic [15:0] fwd_limit_r;
  logic [15:0] rev_limit_r;
  logic [15:0] target_torque_r;
  logic [15:0] torque_demand_r;
  logic [15:0] meas_torque_r;
  logic        cw_bit7_r;
  logic        remote_r;
  ctm_state_t  state_r;
  ctm_state_t  state_nxt;
  logic [15:0] status_word;
  logic        cst_mode;
  logic        fr_rise;
  logic        tq_valid;
  logic        tq_ready;
  logic [15:0] tq_data;
  logic        wr_target;

  assign cst_mode  = (mode_select_r == CTM_MODE_CYCLIC_TORQUE);
  assign wr_target = obj_req.wr && (obj_req.addr == CTM_OFS_TARGET_TORQUE);
  // Target writes stall when four unapplied samples are queued
  assign obj_ready = !wr_target || tq_ready;

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_word_r  <= CTM_RST_CONTROL_WORD;
      mode_select_r   <= CTM_RST_MODE_SELECT;
      max_torque_r    <= CTM_RST_MAX_TORQUE;
      cmd_polarity_r  <= CTM_RST_CMD_POLARITY;
      max_speed_r     <= CTM_RST_MAX_SPEED;
      torque_offset_r <= CTM_RST_TORQUE_OFFSET;
      fwd_limit_r     <= CTM_RST_FWD_LIMIT;
      rev_limit_r     <= CTM_RST_REV_LIMIT;
    end else if (obj_req.wr) begin
      case (obj_req.addr)
        CTM_OFS_CONTROL_WORD:  control_word_r  <= obj_req.wdata[15:0];
        CTM_OFS_MODE_SELECT:   mode_select_r   <= obj_req.wdata[7:0];
        CTM_OFS_MAX_TORQUE:    max_torque_r    <= obj_req.wdata[15:0];
        CTM_OFS_CMD_POLARITY:  cmd_polarity_r  <= obj_req.wdata[7:0];
        CTM_OFS_MAX_SPEED:     max_speed_r     <= obj_req.wdata;
        CTM_OFS_TORQUE_OFFSET: torque_offset_r <= obj_req.wdata[15:0];
        CTM_OFS_FWD_LIMIT:     fwd_limit_r     <= obj_req.wdata[15:0];
        CTM_OFS_REV_LIMIT:     rev_limit_r     <= obj_req.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read answers one cycle after the request; unmapped objects read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      obj_rdata  <= '0;
      obj_rvalid <= 1'b0;
    end else begin
      obj_rvalid <= obj_req.rd;
      if (obj_req.rd) begin
        case (obj_req.addr)
          CTM_OFS_CONTROL_WORD:  obj_rdata <= {16'h0000, control_word_r};
          CTM_OFS_STATUS_WORD:   obj_rdata <= {16'h0000, status_word};
          CTM_OFS_MODE_SELECT:   obj_rdata <= {24'h000000, mode_select_r};
          CTM_OFS_MODE_DISPLAY:  obj_rdata <= {24'h000000, mode_select_r};
          CTM_OFS_TARGET_TORQUE: obj_rdata <= {16'h0000, target_torque_r};
          CTM_OFS_MAX_TORQUE:    obj_rdata <= {16'h0000, max_torque_r};
          CTM_OFS_TORQUE_DEMAND: obj_rdata <= {16'h0000, torque_demand_r};
          CTM_OFS_MEAS_TORQUE:   obj_rdata <= {16'h0000, meas_torque_r};
          CTM_OFS_CMD_POLARITY:  obj_rdata <= {24'h000000, cmd_polarity_r};
          CTM_OFS_MAX_SPEED:     obj_rdata <= max_speed_r;
          CTM_OFS_TORQUE_OFFSET: obj_rdata <= {16'h0000, torque_offset_r};
          CTM_OFS_FWD_LIMIT:     obj_rdata <= {16'h0000, fwd_limit_r};
          CTM_OFS_REV_LIMIT:     obj_rdata <= {16'h0000, rev_limit_r};
          default:               obj_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Queue of received targets, drained one per sync boundary
  ctm_fifo #(
    .WIDTH (CTM_FIFO_WIDTH),
    .DEPTH (CTM_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_target),
    .in_ready  (tq_ready),
    .in_data   (obj_req.wdata[15:0]),
    .out_valid (tq_valid),
    .out_ready (sync_pulse),
    .out_data  (tq_data)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_torque_r <= CTM_RST_TARGET_TORQUE;
    end else if (sync_pulse && tq_valid) begin
      target_torque_r <= tq_data;
    end
  end

  // Demand follows the target plus offset, clamped by limits; no ramping
  function automatic logic [15:0] ctm_clamp(input logic signed [17:0] v,
                                            input logic [15:0] fwd,
                                            input logic [15:0] rev);
    logic signed [17:0] hi;
    logic signed [17:0] lo;
    hi = $signed({2'b00, fwd});
    lo = -$signed({2'b00, rev});
    if (v > hi) begin
      ctm_clamp = hi[15:0];
    end else if (v < lo) begin
      ctm_clamp = lo[15:0];
    end else begin
      ctm_clamp = v[15:0];
    end
  endfunction

  logic signed [17:0] tq_sum;
  logic [15:0]        lim_fwd;
  logic [15:0]        lim_rev;
  assign tq_sum  = 18'($signed(target_torque_r)) + 18'($signed(torque_offset_r));
  assign lim_fwd = (fwd_limit_r < max_torque_r) ? fwd_limit_r : max_torque_r;
  assign lim_rev = (rev_limit_r < max_torque_r) ? rev_limit_r : max_torque_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      torque_demand_r <= '0;
      meas_torque_r   <= '0;
    end else begin
      meas_torque_r <= measured_torque_in;
      if (cst_mode && state_r == CTM_ST_OP_ENABLED) begin
        torque_demand_r <= ctm_clamp(tq_sum, lim_fwd, lim_rev);
      end else begin
        torque_demand_r <= '0;
      end
    end
  end
  assign torque_cmd = torque_demand_r;

  // Fault reset edge; bit 7 high masks other command bits
  assign fr_rise = control_word_r[CTM_CW_FAULT_RESET] && !cw_bit7_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_bit7_r         <= 1'b0;
      fault_reset_pulse <= 1'b0;
      alarm_clear_pulse <= 1'b0;
    end else begin
      cw_bit7_r         <= control_word_r[CTM_CW_FAULT_RESET];
      fault_reset_pulse <= fr_rise;
      alarm_clear_pulse <= fr_rise && alarm_in && alarm_clearable;
    end
  end

  // Bits 4..6 and 8..15 are never decoded, so they are inert
  always_comb begin
    logic so;
    logic ev;
    logic qs;
    logic oe;
    so = control_word_r[CTM_CW_SWITCH_ON];
    ev = control_word_r[CTM_CW_EN_VOLTAGE];
    qs = control_word_r[CTM_CW_QUICK_STOP];
    oe = control_word_r[CTM_CW_OP_ENABLE];
    state_nxt = state_r;
    if (control_word_r[CTM_CW_FAULT_RESET]) begin
      if (state_r == CTM_ST_FAULT && fr_rise && !fault_in) begin
        state_nxt = CTM_ST_ON_DISABLED;
      end
    end else begin
      case (state_r)
        CTM_ST_ON_DISABLED: if (ev && qs && !so) state_nxt = CTM_ST_READY;
        CTM_ST_READY: begin
          if (!ev || !qs) state_nxt = CTM_ST_ON_DISABLED;
          else if (so) state_nxt = CTM_ST_SWITCHED_ON;
        end
        CTM_ST_SWITCHED_ON: begin
          if (!ev || !qs) state_nxt = CTM_ST_ON_DISABLED;
          else if (!so) state_nxt = CTM_ST_READY;
          else if (oe && cst_mode) state_nxt = CTM_ST_OP_ENABLED;
        end
        CTM_ST_OP_ENABLED: begin
          if (!qs) state_nxt = CTM_ST_QUICK_STOP;
          else if (!ev) state_nxt = CTM_ST_ON_DISABLED;
          else if (!so) state_nxt = CTM_ST_READY;
          else if (!oe || !cst_mode) state_nxt = CTM_ST_SWITCHED_ON;
        end
        CTM_ST_QUICK_STOP: if (!ev || !so) state_nxt = CTM_ST_ON_DISABLED;
        CTM_ST_FAULT: state_nxt = CTM_ST_FAULT;
        default: state_nxt = CTM_ST_ON_DISABLED;
      endcase
    end
    if (fault_in) begin
      state_nxt = CTM_ST_FAULT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= CTM_ST_ON_DISABLED;
      remote_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (obj_req.wr && obj_req.addr == CTM_OFS_CONTROL_WORD) begin
        remote_r <= 1'b1;
      end
    end
  end

  assign quick_stop_active = (state_r == CTM_ST_QUICK_STOP);

  always_comb begin
    logic on;
    on = (state_r == CTM_ST_SWITCHED_ON) || (state_r == CTM_ST_OP_ENABLED);
    status_word = 16'h0000;
    status_word[CTM_SW_READY]       = on || (state_r == CTM_ST_READY);
    status_word[CTM_SW_SWITCHED_ON] = on;
    status_word[CTM_SW_VOLTAGE]     = on || (state_r == CTM_ST_READY);
    status_word[CTM_SW_OP_ENABLED]  = (state_r == CTM_ST_OP_ENABLED);
    status_word[CTM_SW_FAULT]       = fault_in || (state_r == CTM_ST_FAULT);
    status_word[CTM_SW_ALARM]       = alarm_in;
    status_word[CTM_SW_QUICK_STOP]  = !quick_stop_active;
    status_word[CTM_SW_ON_DISABLED] = (state_r == CTM_ST_ON_DISABLED);
    status_word[CTM_SW_REMOTE]      = remote_r;
    status_word[CTM_SW_TARGET]      = cst_mode;
    status_word[CTM_SW_FOLLOWING]   = cst_mode;
    status_word[CTM_SW_SW_LIMIT]    = sw_limit_in;
  end

  // Probe inputs cross from pins: three stages, change accepted when 2 and 3 agree
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] stable_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      sync3_r  <= '0;
      stable_r <= '0;
    end else begin
      sync1_r <= {encoder_index_in, probe_di_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == sync3_r[i]) stable_r[i] <= sync3_r[i];
      end
    end
  end

  ctm_probe_cfg_t cfg [2];
  logic [1:0]     src_now;
  logic [1:0]     src_prev_r;
  logic [1:0]     primed_r;
  assign cfg[0] = probe1_cfg;
  assign cfg[1] = probe2_cfg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_probe
      assign src_now[g] = cfg[g].sel_index ? stable_r[2] : stable_r[g];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          src_prev_r[g]         <= 1'b0;
          primed_r[g]           <= 1'b0;
          probe_pos[2*g]        <= '0;
          probe_pos[2*g+1]      <= '0;
          probe_latched[2*g]    <= 1'b0;
          probe_latched[2*g+1]  <= 1'b0;
        end else begin
          primed_r[g]   <= cfg[g].en;
          src_prev_r[g] <= src_now[g];
          if (!cfg[g].en) begin
            probe_latched[2*g]   <= 1'b0;
            probe_latched[2*g+1] <= 1'b0;
          end else if (primed_r[g]) begin
            // Rising edge slot
            if (cfg[g].pos_en && src_now[g] && !src_prev_r[g]
                && (cfg[g].continuous || !probe_latched[2*g])) begin
              probe_pos[2*g]     <= position_in;
              probe_latched[2*g] <= 1'b1;
            end
            // Falling edge slot
            if (cfg[g].neg_en && !src_now[g] && src_prev_r[g]
                && (cfg[g].continuous || !probe_latched[2*g+1])) begin
              probe_pos[2*g+1]     <= position_in;
              probe_latched[2*g+1] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: ctm_host.sv
// Host controller model: object access strobes and sync boundary strobe
`timescale 1ns/100ps
`default_nettype none
module ctm_host
  import ctm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        obj_ready,
  input  wire logic [31:0] obj_rdata,
  input  wire logic        obj_rvalid,
  output var ctm_obj_req_t obj_req,
  output var logic         sync_pulse
);
  initial begin
    obj_req = '0;
    sync_pulse = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until a high ready is seen; tries bounds a refused write
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input int tries,
                    output logic taken);
    logic rdy;
    taken = 1'b0;
    @(posedge clk);
    obj_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    for (int i = 0; i < tries && !taken; i++) begin
      @(negedge clk);
      rdy = obj_ready;
      @(posedge clk);
      taken = (rdy === 1'b1);
    end
    obj_req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    obj_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    obj_req <= '0;
    @(negedge clk);
    ok = (obj_rvalid === 1'b1);
    d = obj_rdata;
  endtask
  // One target is consumed per boundary, so the host paces its ramp here
  task automatic sync();
    @(posedge clk);
    sync_pulse <= 1'b1;
    @(posedge clk);
    sync_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: ctm_properties.sv
// Checker: port-level timing relations of the cyclic torque mode block
`timescale 1ns/100ps
`default_nettype none
module ctm_properties
  import ctm_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire ctm_obj_req_t   obj_req,
  input wire logic           obj_ready,
  input wire logic [31:0]    obj_rdata,
  input wire logic           obj_rvalid,
  input wire ctm_probe_cfg_t probe1_cfg,
  input wire logic [15:0]    torque_cmd,
  input wire logic           quick_stop_active,
  input wire logic           fault_reset_pulse,
  input wire logic           alarm_clear_pulse,
  input wire logic [31:0]    probe_pos [4],
  input wire logic [3:0]     probe_latched
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_req;
    obj_req.rd;
  endsequence
  sequence s_read_ans;
    obj_rvalid;
  endsequence
  sequence s_qs_held;
    quick_stop_active ##1 quick_stop_active;
  endsequence
  a_refuse_only_target: assert property (!obj_ready |->
    obj_req.wr && obj_req.addr == CTM_OFS_TARGET_TORQUE) else $error("ready low off target");
  a_read_answer: assert property (s_read_req |=> s_read_ans)
    else $error("no read valid");
  a_read_cause: assert property (obj_rvalid |-> $past(obj_req.rd))
    else $error("read valid without read");
  a_rdata_hold: assert property (!$past(obj_req.rd) |-> $stable(obj_rdata))
    else $error("read data moved");
  a_reset_single: assert property (fault_reset_pulse |=> !fault_reset_pulse)
    else $error("fault reset repeated");
  a_reset_cause: assert property (fault_reset_pulse |-> $past(obj_req.wr &&
    obj_req.addr == CTM_OFS_CONTROL_WORD && obj_req.wdata[7], 2)) else $error("reset uncaused");
  a_alarm_with_reset: assert property (alarm_clear_pulse |-> fault_reset_pulse)
    else $error("alarm clear alone");
  a_qs_torque_zero: assert property (s_qs_held |-> torque_cmd == 16'h0000)
    else $error("torque during quick stop");
  a_probe_single_hold: assert property (probe_latched[0] && $past(probe_latched[0]) &&
    probe1_cfg.en && $past(probe1_cfg.en) && !probe1_cfg.continuous &&
    !$past(probe1_cfg.continuous) |-> $stable(probe_pos[0])) else $error("single latch moved");
  a_probe_flagged: assert property ($changed(probe_pos[0]) |-> probe_latched[0])
    else $error("latch without flag");
endmodule
bind ctm_top ctm_properties u_ctm_properties (.clk(clk), .rst_n(rst_n), .obj_req(obj_req),
  .obj_ready(obj_ready), .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid),
  .probe1_cfg(probe1_cfg), .torque_cmd(torque_cmd), .quick_stop_active(quick_stop_active),
  .fault_reset_pulse(fault_reset_pulse), .alarm_clear_pulse(alarm_clear_pulse),
  .probe_pos(probe_pos), .probe_latched(probe_latched));
`default_nettype wire

// file: ctm_top_tb.sv
// Testbench: registers, enabling, torque queue, faults and position probes
`timescale 1ns/100ps
`default_nettype none
module ctm_top_tb
  import ctm_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  ctm_obj_req_t   obj_req;
  logic           obj_ready, obj_rvalid, sync_pulse, taken;
  logic [31:0]    obj_rdata, position_in;
  logic           fault_in, alarm_in, alarm_clearable, sw_limit_in, encoder_index_in;
  logic [1:0]     probe_di_in;
  ctm_probe_cfg_t probe1_cfg, probe2_cfg;
  logic [15:0]    torque_cmd, meas_tq;
  logic           quick_stop_active, fault_reset_pulse, alarm_clear_pulse;
  logic [31:0]    probe_pos [4];
  logic [3:0]     probe_latched;
  int             num_errors = 0;
  int             check_count = 0;
  int             cycle_count = 0;
  int             fr_cnt = 0;
  int             ac_cnt = 0;
  localparam logic [15:0] RST_ADDR [9] = '{CTM_OFS_CONTROL_WORD, CTM_OFS_MODE_SELECT,
    CTM_OFS_TARGET_TORQUE, CTM_OFS_MAX_TORQUE, CTM_OFS_CMD_POLARITY, CTM_OFS_MAX_SPEED,
    CTM_OFS_TORQUE_OFFSET, CTM_OFS_FWD_LIMIT, CTM_OFS_REV_LIMIT};
  localparam logic [31:0] RST_VAL [9] = '{32'h0, 32'h0, 32'h0, 32'h0BB8, 32'h0,
    32'h0640_0000, 32'h0, 32'h0BB8, 32'h0BB8};
  // Ramp steps, two beyond the 3000 limits to see the clamp
  localparam logic [15:0] TQ_IN [4] = '{16'h07D0, 16'h0FA0, 16'hF060, 16'hFC18};
  localparam logic [15:0] TQ_OUT [4] = '{16'h07D0, 16'h0BB8, 16'hF448, 16'hFC18};
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (fault_reset_pulse === 1'b1) fr_cnt++;
    if (alarm_clear_pulse === 1'b1) ac_cnt++;
  end
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  ctm_top u_ctm_top (.clk(clk), .rst_n(rst_n), .obj_req(obj_req), .obj_ready(obj_ready),
    .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid), .sync_pulse(sync_pulse),
    .fault_in(fault_in), .alarm_in(alarm_in), .alarm_clearable(alarm_clearable),
    .sw_limit_in(sw_limit_in), .measured_torque_in(meas_tq), .position_in(position_in),
    .probe_di_in(probe_di_in), .encoder_index_in(encoder_index_in), .probe1_cfg(probe1_cfg),
    .probe2_cfg(probe2_cfg), .torque_cmd(torque_cmd), .quick_stop_active(quick_stop_active),
    .fault_reset_pulse(fault_reset_pulse), .alarm_clear_pulse(alarm_clear_pulse),
    .probe_pos(probe_pos), .probe_latched(probe_latched));
  ctm_host u_ctm_host (.clk(clk), .obj_ready(obj_ready), .obj_rdata(obj_rdata),
    .obj_rvalid(obj_rvalid), .obj_req(obj_req), .sync_pulse(sync_pulse));
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [31:0] d);
    u_ctm_host.wr(a, d, 1, taken);
    check({31'h0, taken}, 32'h1);
  endtask
  // Status settles two cycles after a write, so each read waits first
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    u_ctm_host.idle(3);
    u_ctm_host.rd(a, d, ok);
    check({31'h0, ok}, 32'h1);
    check(d & m, e);
  endtask
  // Pins pass a three-stage synchroniser, so position is held ten cycles
  task automatic pin(input logic [31:0] p, input int k, input logic v);
    @(posedge clk);
    position_in <= p;
    @(posedge clk);
    if (k < 2) probe_di_in[k] <= v;
    else encoder_index_in <= v;
    repeat (10) @(posedge clk);
  endtask
  initial begin
    {fault_in, alarm_in, alarm_clearable, sw_limit_in, encoder_index_in} = '0;
    probe_di_in = 2'b00;
    position_in = 32'h0;
    meas_tq = 16'h0123;
    probe1_cfg = '0;
    probe2_cfg = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(RST_ADDR[i], 32'hFFFF_FFFF, RST_VAL[i]);
    rd_chk(16'h1234, 32'hFFFF_FFFF, 32'h0);
    put(CTM_OFS_STATUS_WORD, 32'hFFFF);
    rd_chk(CTM_OFS_STATUS_WORD, 32'hFEED, 32'h0060);
    rd_chk(CTM_OFS_MEAS_TORQUE, 32'hFFFF_FFFF, 32'h0123);
    put(CTM_OFS_MAX_SPEED, 32'h1234_5678);
    meas_tq <= 16'hFE0C;
    rd_chk(CTM_OFS_MAX_SPEED, 32'hFFFF_FFFF, 32'h1234_5678);
    rd_chk(CTM_OFS_MEAS_TORQUE, 32'hFFFF_FFFF, 32'hFE0C);
    put(CTM_OFS_MODE_SELECT, 32'h0A);
    rd_chk(CTM_OFS_MODE_DISPLAY, 32'hFF, 32'h0A);
    rd_chk(CTM_OFS_STATUS_WORD, 32'hFEED, 32'h1460);
    put(CTM_OFS_CONTROL_WORD, 32'h80);
    put(CTM_OFS_CONTROL_WORD, 32'h8F);
    rd_chk(CTM_OFS_STATUS_WORD, 32'h0005, 32'h0);
    put(CTM_OFS_CONTROL_WORD, 32'h06);
    rd_chk(CTM_OFS_STATUS_WORD, 32'hFEED, 32'h1621);
    put(CTM_OFS_CONTROL_WORD, 32'h07);
    rd_chk(CTM_OFS_STATUS_WORD, 32'hFEED, 32'h1621);
    put(CTM_OFS_CONTROL_WORD, 32'h0F);
    rd_chk(CTM_OFS_STATUS_WORD, 32'hFEED, 32'h1625);
    check(fr_cnt, 1);
    put(CTM_OFS_TARGET_TORQUE, 32'h03E8);
    u_ctm_host.idle(3);
    check({16'h0, torque_cmd}, 32'h0);
    u_ctm_host.sync();
    u_ctm_host.idle(2);
    check({16'h0, torque_cmd}, 32'h03E8);
    for (int i = 0; i < 4; i++) put(CTM_OFS_TARGET_TORQUE, {16'h0, TQ_IN[i]});
    u_ctm_host.wr(CTM_OFS_TARGET_TORQUE, 32'h0BB8, 1, taken);
    check({31'h0, taken}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_ctm_host.sync();
      u_ctm_host.idle(2);
      check({16'h0, torque_cmd}, {16'h0, TQ_OUT[i]});
    end
    rd_chk(CTM_OFS_TARGET_TORQUE, 32'hFFFF_FFFF, 32'hFC18);
    put(CTM_OFS_CONTROL_WORD, 32'h0B);
    u_ctm_host.idle(4);
    check({31'h0, quick_stop_active}, 32'h1);
    check({16'h0, torque_cmd}, 32'h0);
    rd_chk(CTM_OFS_STATUS_WORD, 32'h0020, 32'h0);
    put(CTM_OFS_CONTROL_WORD, 32'h00);
    u_ctm_host.idle(4);
    check({31'h0, quick_stop_active}, 32'h0);
    {fault_in, alarm_in, alarm_clearable, sw_limit_in} <= 4'hF;
    rd_chk(CTM_OFS_STATUS_WORD, 32'h0888, 32'h0888);
    @(posedge clk);
    fault_in <= 1'b0;
    put(CTM_OFS_CONTROL_WORD, 32'h80);
    put(CTM_OFS_CONTROL_WORD, 32'h80);
    {alarm_in, sw_limit_in} <= 2'b00;
    rd_chk(CTM_OFS_STATUS_WORD, 32'h08C8, 32'h0040);
    check(fr_cnt, 2);
    check(ac_cnt, 1);
    @(posedge clk);
    probe1_cfg <= '{en: 1'b1, continuous: 1'b0, sel_index: 1'b0, pos_en: 1'b1, neg_en: 1'b1};
    probe2_cfg <= '{en: 1'b1, continuous: 1'b1, sel_index: 1'b1, pos_en: 1'b1, neg_en: 1'b0};
    u_ctm_host.idle(3);
    pin(32'h100, 0, 1'b1);
    pin(32'h200, 0, 1'b0);
    pin(32'h300, 0, 1'b1);
    pin(32'h400, 2, 1'b1);
    pin(32'h450, 2, 1'b0);
    pin(32'h500, 2, 1'b1);
    check(probe_pos[0], 32'h100);
    check(probe_pos[1], 32'h200);
    check(probe_pos[2], 32'h500);
    check({28'h0, probe_latched}, 32'h7);
    // Source switches only between equal levels, so no false edge
    probe1_cfg <= 5'b11101;
    pin(32'h600, 2, 1'b0);
    probe2_cfg <= 5'b10001;
    pin(32'h700, 1, 1'b1);
    pin(32'h800, 1, 1'b0);
    check(probe_pos[1], 32'h600);
    check(probe_pos[3], 32'h800);
    check({28'h0, probe_latched}, 32'hF);
    end_of_test();
  end
endmodule
`default_nettype wire
